// ===== cwg_bridge_model.sv
// Bridge power stage: pin levels and shoot-through watch
`timescale 1ns/100ps
module cwg_bridge_model (
	input wire logic	core_clk_i,
	input wire cwg_pkg::cwg_quad_t	pin_i,
	input wire cwg_pkg::cwg_quad_t	oe_i,
	input wire cwg_pkg::cwg_quad_t	pol_low_i,
	output logic	shoot_o
);
	// Released pins fall to the pull-down level
	wire cwg_pkg::cwg_quad_t	lvl = pin_i & oe_i;
	wire cwg_pkg::cwg_quad_t	on = lvl ^ pol_low_i;
	initial shoot_o = 1'h0;
	always @(posedge core_clk_i)
		if ((on.a && on.b) || (on.c && on.d))
			shoot_o <= 1'h1;
endmodule

// ===== cwg_core.sv
// Complementary waveform generator core
//
// Function
// - Three-bit mode field selects one of six modes; 100 half-bridge, 101 push-pull.
// - Half-bridge drives a true copy and an inverted copy of the input.
// - Half-bridge inserts dead band so both outputs are never active together.
// - Steering selections are ignored in half-bridge mode.
// - Half-bridge: C follows A, D follows B, each with own polarity.
// - Push-pull routes successive input pulses alternately to A and B.
// - Push-pull sequencer resets while disabled or on auto-shutdown.
// - Sequencer advances on input pulses; first pulse after reset goes to A.
// - Push-pull: C copies A, D copies B, each with own polarity.
// - Full-bridge holds three outputs static and modulates the fourth.
// - Direction may change by toggling mode bit zero while enabled.
// - Forward: A active, B and C inactive, D modulated.
// - Reverse: C active, A and D inactive, B modulated.
// - Full-bridge applies dead band on a direction switch and after enable.
// - Steering selections are ignored in both full-bridge modes.
// - Every output has its own polarity setting.
// - Two independent 6-bit dead-band timers, rising and falling.
// - Rising and falling dead band enable independently.
// - Auto-shutdown in every mode with override levels and optional restart.
// - Turn-on of an output delays after turn-off of its complement.
// - One pulse data input, at most four outputs.
// - Code 001 synchronous steering, 000 asynchronous; sync applies on input rise.
// - Dead band counts clock periods from zero up to programmed value.
// - Full-bridge direction change takes effect on next input rising edge.
// - Clock-source select picks system clock or fast oscillator for dead band.
`timescale 1ns/100ps

module cwg_core
	(
		// Clock and reset
		input  wire logic                         core_clk_i,
		input  wire logic                         nrst_i,
		// Data and control
		input  wire logic                         data_i,
		input  wire logic                         enable_i,
		input  wire logic [2:0]                   mode_i,
		input  wire cwg_pkg::cwg_quad_t           pol_low_i,
		input  wire cwg_pkg::cwg_db_cfg_t         db_cfg_i,
		// Dead-band clock source
		input  wire logic                         clk_sel_fast_i,
		input  wire logic                         fast_osc_tick_i,
		// Steering
		input  wire cwg_pkg::cwg_quad_t           steer_i,
		input  wire cwg_pkg::cwg_quad_t           steer_lvl_i,
		// Auto-shutdown
		input  wire logic [3:0]                   fault_i,
		input  wire logic [3:0]                   fault_mask_i,
		input  wire logic                         auto_restart_i,
		input  wire logic                         sd_clear_i,
		input  wire logic [1:0]                   sd_lvl_ac_i,
		input  wire logic [1:0]                   sd_lvl_bd_i,
		// Outputs
		output cwg_pkg::cwg_quad_t                out_o,
		output cwg_pkg::cwg_quad_t                out_oe_o,
		output logic                              shutdown_o,
		output logic                              direction_rev_o
	);

	localparam int W = cwg_pkg::DB_W;

	// Saturating dead-band count step
	function automatic logic [W-1:0] db_step(input logic [W-1:0] cnt,
	                                         input logic [W-1:0] tgt,
	                                         input logic         tick);
		db_step = (tick && cnt != tgt) ? cnt + W'(1) : cnt;
	endfunction

	// Shutdown level: value and drive enable for one pin
	function automatic logic [1:0] sd_pin(input logic [1:0] lvl,
	                                      input logic       pol);
		case (lvl)
			cwg_pkg::SD_HIGH_Z: sd_pin = 2'h0;
			cwg_pkg::SD_LOW:    sd_pin = 2'h1;
			cwg_pkg::SD_HIGH:   sd_pin = 2'h3;
			default:            sd_pin = {pol, 1'b1};
		endcase
	endfunction

	logic              data_r;
	logic [W-1:0]      rcnt_r;
	logic [W-1:0]      rcnt_nxt;
	logic [W-1:0]      fcnt_r;
	logic [W-1:0]      fcnt_nxt;
	logic [W-1:0]      bcnt_r;
	logic [W-1:0]      bcnt_nxt;
	logic              seq_r;
	logic              sel_r;
	logic              dir_r;
	logic              sd_r;
	cwg_pkg::cwg_quad_t steer_sync_r;
	cwg_pkg::cwg_quad_t out_r;
	cwg_pkg::cwg_quad_t oe_r;

	// Mode decode
	wire logic mode_hb    = mode_i == cwg_pkg::MODE_HALF_BRIDGE;
	wire logic mode_pp    = mode_i == cwg_pkg::MODE_PUSH_PULL;
	wire logic mode_fb    = mode_i[2:1] == cwg_pkg::MODE_FB_FWD[2:1];
	wire logic mode_sync  = mode_i == cwg_pkg::MODE_SYNC_STEER;
	wire logic mode_steer = mode_sync || mode_i == cwg_pkg::MODE_ASYNC_STEER;

	wire logic rise = data_i && !data_r;

	wire logic db_tick = clk_sel_fast_i ? fast_osc_tick_i : 1'b1;

	// Independent enables; disabled means zero delay
	wire logic [W-1:0] rtgt = db_cfg_i.rise_en ? db_cfg_i.rise_cnt : '0;
	wire logic [W-1:0] ftgt = db_cfg_i.fall_en ? db_cfg_i.fall_cnt : '0;

	// Count from zero up to target
	assign rcnt_nxt = (!enable_i || !data_i) ? '0 : db_step(rcnt_r, rtgt, db_tick);
	assign fcnt_nxt = (!enable_i || data_i) ? '0 : db_step(fcnt_r, ftgt, db_tick);

	// Turn-on waits after complement turns off
	wire logic hb_true = data_i && rcnt_r == rtgt;
	wire logic hb_inv  = !data_i && fcnt_r == ftgt;

	// First pulse after reset goes to A
	wire logic pp_sel  = rise ? seq_r : sel_r;
	// Alternate pulses between A and B
	wire logic pp_a    = data_i && !pp_sel;
	wire logic pp_b    = data_i && pp_sel;

	// Direction applies on input rising edge
	wire logic dir_chg = mode_fb && rise && (mode_i[0] != dir_r);
	wire logic dir_now = dir_chg ? mode_i[0] : dir_r;

	// Dead band on direction switch and after enable; reverse uses rising timer
	wire logic [W-1:0] btgt = mode_i[0] ? rtgt : ftgt;
	assign bcnt_nxt = !enable_i ? '0 :
	                  dir_chg   ? '0 :
	                  db_step(bcnt_r, dir_r ? rtgt : ftgt, db_tick);
	wire logic fb_mod  = data_i && !dir_chg && bcnt_r == (dir_r ? rtgt : ftgt);

	// Steering selection, sync mode latched at input rise
	wire cwg_pkg::cwg_quad_t steer_eff = mode_sync ? steer_sync_r : steer_i;

	// Fault detection
	wire logic fault_hit  = enable_i && |(fault_i & fault_mask_i);
	wire logic fault_gone = !(|(fault_i & fault_mask_i));

	// Active-high waveform per pin before polarity
	cwg_pkg::cwg_quad_t raw;
	// Pins that take part in modulation and shutdown
	cwg_pkg::cwg_quad_t used;

	always_comb
	begin
		raw  = '0;
		used = '1;
		case (mode_i)
			cwg_pkg::MODE_HALF_BRIDGE:
			begin
				// C follows A, D follows B
				raw = '{a: hb_true, b: hb_inv, c: hb_true, d: hb_inv};
			end
			cwg_pkg::MODE_PUSH_PULL:
			begin
				// C copies A, D copies B
				raw = '{a: pp_a, b: pp_b, c: pp_a, d: pp_b};
			end
			cwg_pkg::MODE_FB_FWD,
			cwg_pkg::MODE_FB_REV:
			begin
				raw = '{a: !dir_now, b: dir_now && fb_mod, c: dir_now, d: !dir_now && fb_mod};
			end
			cwg_pkg::MODE_ASYNC_STEER,
			cwg_pkg::MODE_SYNC_STEER:
			begin
				raw  = {4{data_i}};
				used = steer_eff;
			end
			default:
			begin
				raw = '0;
			end
		endcase
	end

	// Shutdown drive per pin pair
	wire logic [1:0] sd_a = sd_pin(sd_lvl_ac_i, pol_low_i.a);
	wire logic [1:0] sd_b = sd_pin(sd_lvl_bd_i, pol_low_i.b);
	wire logic [1:0] sd_c = sd_pin(sd_lvl_ac_i, pol_low_i.c);
	wire logic [1:0] sd_d = sd_pin(sd_lvl_bd_i, pol_low_i.d);
	wire cwg_pkg::cwg_quad_t sd_val = '{a: sd_a[1], b: sd_b[1], c: sd_c[1], d: sd_d[1]};
	wire cwg_pkg::cwg_quad_t sd_oe  = '{a: sd_a[0], b: sd_b[0], c: sd_c[0], d: sd_d[0]};

	wire cwg_pkg::cwg_quad_t drive = raw ^ pol_low_i;

	wire cwg_pkg::cwg_quad_t run_val = (used & drive) | (~used & steer_lvl_i);

	// Restart: automatic on input rise, or by clear, once fault is gone
	wire logic sd_release = fault_gone && (auto_restart_i ? rise : sd_clear_i);
	wire logic sd_nxt     = enable_i && (fault_hit || (sd_r && !sd_release));

	// Shutdown overrides only participating pins, in step with the flag
	wire logic                sd_act  = sd_nxt;
	wire cwg_pkg::cwg_quad_t  sd_use  = sd_act ? used : '0;
	wire cwg_pkg::cwg_quad_t  out_nxt = !enable_i ? pol_low_i :
	                                    (sd_use & sd_val) | (~sd_use & run_val);
	wire cwg_pkg::cwg_quad_t  oe_nxt  = ~sd_use | sd_oe;

	// Sequencer reset on disable or shutdown
	wire logic seq_nxt = (!enable_i || sd_act) ? cwg_pkg::SEQ_RST :
	                     (mode_pp && rise) ? !seq_r : seq_r;
	wire logic sel_nxt = (!enable_i || sd_act) ? cwg_pkg::SEQ_RST : pp_sel;

	// Direction follows mode bit zero while disabled, else only on full-bridge input rise
	wire logic dir_nxt = !enable_i ? mode_i[0] : (mode_fb ? dir_now : dir_r);

	wire cwg_pkg::cwg_quad_t steer_sync_nxt = rise ? steer_i : steer_sync_r;

	// Edge detect and counters
	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			data_r <= 1'b0;
			rcnt_r <= '0;
			fcnt_r <= '0;
			bcnt_r <= '0;
		end
		else
		begin
			data_r <= data_i;
			rcnt_r <= rcnt_nxt;
			fcnt_r <= fcnt_nxt;
			bcnt_r <= bcnt_nxt;
		end
	end

	// Sequencer, direction, shutdown, steering
	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			seq_r        <= cwg_pkg::SEQ_RST;
			sel_r        <= cwg_pkg::SEQ_RST;
			dir_r        <= cwg_pkg::DIR_RST;
			sd_r         <= 1'b0;
			steer_sync_r <= '0;
		end
		else
		begin
			seq_r        <= seq_nxt;
			sel_r        <= sel_nxt;
			dir_r        <= dir_nxt;
			sd_r         <= sd_nxt;
			steer_sync_r <= steer_sync_nxt;
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			out_r <= '0;
			oe_r  <= '0;
		end
		else
		begin
			out_r <= out_nxt;
			oe_r  <= oe_nxt;
		end
	end

	assign out_o           = out_r;
	assign out_oe_o        = oe_r;
	assign shutdown_o      = sd_r;
	assign direction_rev_o = dir_r;

	// Unused helper kept out of logic
	wire logic unused_btgt = ^btgt;

endmodule

// ===== cwg_pkg.sv
// Constants and carrier types for the complementary waveform generator
package cwg_pkg;

	// Operating mode codes
	localparam logic [2:0] MODE_ASYNC_STEER = 3'h0;
	localparam logic [2:0] MODE_SYNC_STEER  = 3'h1;
	localparam logic [2:0] MODE_FB_FWD      = 3'h2;
	localparam logic [2:0] MODE_FB_REV      = 3'h3;
	localparam logic [2:0] MODE_HALF_BRIDGE = 3'h4;
	localparam logic [2:0] MODE_PUSH_PULL   = 3'h5;

	// Dead-band counter width
	localparam int DB_W = 6;

	// Shutdown override level codes
	localparam logic [1:0] SD_INACTIVE = 2'h0;
	localparam logic [1:0] SD_HIGH_Z   = 2'h1;
	localparam logic [1:0] SD_LOW      = 2'h2;
	localparam logic [1:0] SD_HIGH     = 2'h3;

	// Reset values
	localparam logic       DIR_RST = 1'h0;
	localparam logic       SEQ_RST = 1'h0;

	// One bit per output pin
	typedef struct packed {
		logic a;
		logic b;
		logic c;
		logic d;
	} cwg_quad_t;

	// Dead-band setup
	typedef struct packed {
		logic            rise_en;
		logic            fall_en;
		logic [DB_W-1:0] rise_cnt;
		logic [DB_W-1:0] fall_cnt;
	} cwg_db_cfg_t;

endpackage

// ===== cwg_properties.sv
// Port assertions for the waveform generator core
`timescale 1ns/100ps
module cwg_properties (
	// Clock, reset and controls
	input wire logic	core_clk_i,
	input wire logic	nrst_i,
	input wire logic	data_i,
	input wire logic	enable_i,
	input wire logic [2:0]	mode_i,
	input wire cwg_pkg::cwg_quad_t	pol_low_i,
	input wire logic [3:0]	fault_i,
	input wire logic [3:0]	fault_mask_i,
	// Outputs
	input wire cwg_pkg::cwg_quad_t	out_o,
	input wire logic	shutdown_o,
	input wire logic	direction_rev_o
);
	// Active level of each pin after polarity
	wire cwg_pkg::cwg_quad_t	act = out_o ^ pol_low_i;
	wire logic	run = enable_i && !shutdown_o;
	wire logic	hb = run && mode_i == cwg_pkg::MODE_HALF_BRIDGE;
	wire logic	pp = run && mode_i == cwg_pkg::MODE_PUSH_PULL;
	wire logic	fwd = run && mode_i == cwg_pkg::MODE_FB_FWD && !direction_rev_o;
	wire logic	rev = run && mode_i == cwg_pkg::MODE_FB_REV && direction_rev_o;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i);
	dis_rest_a: assert property ((!enable_i && $stable(pol_low_i)) [*2] |-> out_o == pol_low_i)
		else $error("pins not at rest");
	hb_overlap_a: assert property (hb |-> !(act.a && act.b))
		else $error("half-bridge overlap");
	hb_copy_a: assert property (hb |-> act.c == act.a && act.d == act.b)
		else $error("half-bridge copy lost");
	pp_excl_a: assert property (pp |-> !(act.a && act.b) && act.c == act.a)
		else $error("push-pull overlap");
	fwd_static_a: assert property (fwd [*3] |-> act.a && !act.b && !act.c)
		else $error("forward statics wrong");
	rev_static_a: assert property (rev [*3] |-> act.c && !act.a && !act.d)
		else $error("reverse statics wrong");
	sd_entry_a: assert property (enable_i && |(fault_i & fault_mask_i) |-> ##1 shutdown_o)
		else $error("fault ignored");
	dir_hold_a: assert property (enable_i && mode_i[2:1] == 2'h1 && !$rose(data_i) |=> $stable(direction_rev_o))
		else $error("direction moved early");
endmodule

bind cwg_core cwg_properties u_props (.*);

// ===== test_complementary_waveform_generator.sv
// Self-checking bench for the waveform generator core
`timescale 1ns/100ps
module test_complementary_waveform_generator;
	logic	core_clk_i = 1'h0;
	logic	nrst_i = 1'h0;
	logic	data_i = 1'h0;
	logic	enable_i = 1'h0;
	logic	sd_clear_i = 1'h0;
	logic	shutdown_o;
	logic	direction_rev_o;
	logic	shoot;
	logic [2:0]	mode_i = 3'h0;
	logic [3:0]	fault_i = 4'h0;
	logic [1:0]	sd_lvl_ac_i = cwg_pkg::SD_HIGH;
	logic [1:0]	sd_lvl_bd_i = cwg_pkg::SD_HIGH_Z;
	cwg_pkg::cwg_quad_t	pol_low_i = 4'hA;
	cwg_pkg::cwg_quad_t	steer_i = 4'h8;
	cwg_pkg::cwg_quad_t	steer_lvl_i = 4'h3;
	cwg_pkg::cwg_quad_t	out_o;
	cwg_pkg::cwg_quad_t	out_oe_o;
	cwg_pkg::cwg_db_cfg_t	db_cfg_i = 14'h0;
	int	errors = 0;
	int	cmp_count = 0;
	always #50 core_clk_i = ~core_clk_i;
	cwg_core dut (.clk_sel_fast_i(1'h0), .fast_osc_tick_i(1'h0), .fault_mask_i(4'h1), .auto_restart_i(1'h0), .*);
	cwg_bridge_model u_bridge (.core_clk_i(core_clk_i), .pin_i(out_o), .oe_i(out_oe_o), .pol_low_i(pol_low_i),
		.shoot_o(shoot));
	task automatic step(input int n);
		repeat (n) @(negedge core_clk_i);
	endtask
	task automatic chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic cfg(input logic [2:0] m, input logic [13:0] db);
		enable_i = 1'h0;
		step(2);
		mode_i = m;
		pol_low_i = 4'h3;
		db_cfg_i = db;
		step(1);
		enable_i = 1'h1;
		step(2);
	endtask
	task automatic pulse(input string what, input logic [3:0] exp);
		data_i = 1'h1;
		step(2);
		chk(what, out_o, exp);
		data_i = 1'h0;
		step(2);
	endtask
	task automatic t_rest();
		step(3);
		chk("rest_pins", out_o, 4'hA);
		chk("rest_oe", out_oe_o, 4'hF);
		$display("rest test done");
	endtask
	task automatic t_half();
		cfg(cwg_pkg::MODE_HALF_BRIDGE, 14'h2080);
		data_i = 1'h1;
		step(2);
		chk("hb_gap", out_o, 4'h3);
		step(4);
		chk("hb_high", out_o, 4'h9);
		data_i = 1'h0;
		step(3);
		chk("hb_low", out_o, 4'h6);
		$display("half-bridge test done");
	endtask
	task automatic t_push();
		cfg(cwg_pkg::MODE_PUSH_PULL, 14'h0);
		pulse("pp_first", 4'h9);
		pulse("pp_second", 4'h6);
		pulse("pp_third", 4'h9);
		fault_i = 4'h1;
		step(3);
		chk("sd_flag", {3'h0, shutdown_o}, 4'h1);
		chk("sd_oe", out_oe_o, 4'hA);
		chk("sd_ac", out_o & 4'hA, 4'hA);
		fault_i = 4'h0;
		sd_clear_i = 1'h1;
		step(1);
		sd_clear_i = 1'h0;
		step(2);
		pulse("pp_restart", 4'h9);
		$display("push-pull test done");
	endtask
	task automatic t_bridge();
		cfg(cwg_pkg::MODE_FB_FWD, 14'h30C3);
		data_i = 1'h1;
		step(2);
		chk("fwd_high", out_o, 4'hA);
		data_i = 1'h0;
		mode_i = cwg_pkg::MODE_FB_REV;
		step(4);
		chk("fwd_hold", out_o, 4'hB);
		data_i = 1'h1;
		step(3);
		chk("rev_gap", out_o, 4'h1);
		chk("dir_rev", {3'h0, direction_rev_o}, 4'h1);
		step(6);
		chk("rev_high", out_o, 4'h5);
		$display("full-bridge test done");
	endtask
	task automatic t_steer();
		for (int m = 0; m < 2; m++)
		begin
			cfg(3'(m), 14'h0);
			pulse("steer_first", 4'hB);
			pulse("steer_second", 4'hB);
			chk("steer_low", out_o, 4'h3);
		end
		$display("steering test done");
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		step(7);
		nrst_i = 1'h1;
		t_rest();
		t_half();
		t_push();
		t_bridge();
		t_steer();
		chk("no_shoot", {3'h0, shoot}, 4'h0);
		complete_run();
	end
	// Tests need about 100 cycles
	initial
	begin
		repeat (600) @(posedge core_clk_i);
		errors++;
		complete_run();
	end
endmodule
